/* File: design/pnp_pkg.sv */
// Constants and carrier types for the next-page and port configuration register bank
package pnp_pkg;

   localparam int ADDR_W = 8;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_LP_BASE = 8'h05;
   localparam logic [7:0] IDX_EXPANSION = 8'h06;
   localparam logic [7:0] IDX_NP_TX = 8'h07;
   localparam logic [7:0] IDX_NP_RX = 8'h08;
   localparam logic [7:0] IDX_PORT_CFG = 8'h10;

   localparam logic [15:0] NP_TX_RST = 16'h2001;
   localparam logic [15:0] NP_TX_WMASK = 16'hBFFF;
   localparam logic [15:0] CFG_RST = 16'h0084;
   localparam logic [15:0] CFG_WMASK = 16'hFFFF;
   localparam int EXP_PAGE_RCVD_BIT = 1;
   localparam int EXP_BASE_PAGE_BIT = 5;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   localparam logic [1:0] SLEEP_CODE_UNUSED = 2'h3;
   localparam int CLK_MHZ = 100;
   localparam int SLEEP_T0_MS = 3040;
   localparam int SLEEP_T1_MS = 2000;
   localparam int SLEEP_T2_MS = 1040;
   localparam int SLEEP_CYC_0 = SLEEP_T0_MS * 1000 * CLK_MHZ;
   localparam int SLEEP_CYC_1 = SLEEP_T1_MS * 1000 * CLK_MHZ;
   localparam int SLEEP_CYC_2 = SLEEP_T2_MS * 1000 * CLK_MHZ;

   typedef struct packed {
      logic more_pages_flag;
      logic acknowledge;
      logic message_page_select;
      logic second_acknowledge;
      logic toggle;
      logic [10:0] code;
   } pnp_np_word_type;

   typedef struct packed {
      logic rsv15;
      logic force_link_pass;
      logic tx_disable;
      logic scrambler_bypass;
      logic rsv11;
      logic jabber_disable;
      logic heartbeat_enable;
      logic loopback_disable;
      logic crs_extend;
      logic sleep_enable;
      logic preamble_enable;
      logic [1:0] sleep_delay;
      logic fefi_enable;
      logic alt_next_page_enable;
      logic fiber_select;
   } pnp_cfg_type;

   typedef struct packed {
      logic force_link_pass;
      logic tx_enable;
      logic scrambler_bypass;
      logic jabber_disable;
      logic heartbeat_enable;
      logic loopback_disable;
      logic fefi_enable;
      logic fiber_select;
   } pnp_phy_ctl_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [ADDR_W-1:0] awaddr;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      pnp_np_word_type np_tx;
      pnp_np_word_type np_rx;
      logic [15:0] lp_base;
      logic page_rcvd;
      logic base_page;
      pnp_cfg_type cfg;
      logic strap_done;
      logic [31:0] sleep_cnt;
      logic sleep_active;
      logic crs_out;
      logic rx_dv_out;
      pnp_phy_ctl_type ctl;
   } pnp_state_type;

   localparam pnp_state_type ST_RST = '{
      awready: 1'b1,
      wready: 1'b1,
      arready: 1'b1,
      np_tx: pnp_np_word_type'(NP_TX_RST),
      cfg: pnp_cfg_type'(CFG_RST),
      default: '0
   };

endpackage : pnp_pkg

/* File: design/pnp_regs.sv */
// AXI4-Lite register bank: next-page exchange words and port configuration
//
// Behaviour
// - Transmit bit 15 is more-pages flag, reset 0
// - Transmit bit 13 message select, reset 1; code 1
// - Transmit bit 12 is second acknowledge, reset 0
// - Transmit toggle flips after each page sent
// - Receive bit 15 shows partner more pages
// - Receive bit 14 shows partner acknowledge
// - Receive bit 13 partner message select; reset zero
// - Receive bit 12 shows partner second acknowledge
// - Receive bit 11 shows partner toggle
// - Config bit 14 forces link pass
// - Config bit 13 disables twisted-pair transmitter
// - Config bit 12 bypasses scrambler at 100M
// - Config bit 10 disables jabber at 10M
// - Config bit 9 enables heartbeat at 10M
// - Config bit 8 stops half-duplex loopback at 10M
// - Config bit 7 extends CRS to RX_DV at 10M
// - Config bit 6 sleep enable, strap default
// - Preamble bit chooses when RX_DV rises at 10M
// - Sleep delay code selects idle time
// - Config bit 2 enables far-end fault, reset 1
// - Config bit 1 enables base-page flag
// - Config bit 0 fiber select, strap default
// - Received page loads register, sets flag
// - Alt mode also clears page-received flag
`timescale 1ns/100ps

module pnp_regs #(
   parameter int unsigned SLEEP_CYC_0 = pnp_pkg::SLEEP_CYC_0,
   parameter int unsigned SLEEP_CYC_1 = pnp_pkg::SLEEP_CYC_1,
   parameter int unsigned SLEEP_CYC_2 = pnp_pkg::SLEEP_CYC_2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [pnp_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [pnp_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_strap,
   input wire logic media_select_strap,
   input wire logic page_rx_valid,
   input wire logic page_rx_is_next,
   input wire logic [15:0] page_rx_word,
   input wire logic page_rx_var,
   input wire logic np_tx_sent,
   input wire logic speed_100,
   input wire logic full_duplex,
   input wire logic link_idle,
   input wire logic crs_in,
   input wire logic rx_dv_in,
   output pnp_pkg::pnp_np_word_type np_tx_word,
   output pnp_pkg::pnp_phy_ctl_type phy_ctl,
   output logic sleep_active,
   output logic crs_out,
   output logic rx_dv_out
);

   // Index decode reads address bits 7:2, so narrower buses cannot be served
   if (pnp_pkg::ADDR_W < 8) begin : g_chk_addr
      $error("Address width too small for register map");
   end
   if (SLEEP_CYC_0 < 1 || SLEEP_CYC_1 < 1 || SLEEP_CYC_2 < 1) begin : g_chk_sleep
      $error("Sleep delays must be at least one cycle");
   end

   pnp_pkg::pnp_state_type st_ff;
   pnp_pkg::pnp_state_type nxt_st;
   logic [7:0] wr_idx;
   logic [7:0] rd_idx;
   logic wr_go;
   logic rd_go;
   logic [31:0] sleep_lim;

   function automatic logic [15:0] merge_lanes(input logic [15:0] old_v, input logic [15:0] new_v,
                                              input logic [1:0] strb, input logic [15:0] mask);
      logic [15:0] r;
      r = old_v;
      for (int i = 0; i < 2; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = (old_v[8*i +: 8] & ~mask[8*i +: 8]) | (new_v[8*i +: 8] & mask[8*i +: 8]);
         end
      end
      return r;
   endfunction : merge_lanes

   function automatic logic idx_mapped(input logic [7:0] idx);
      return idx == pnp_pkg::IDX_LP_BASE || idx == pnp_pkg::IDX_EXPANSION || idx == pnp_pkg::IDX_NP_TX ||
             idx == pnp_pkg::IDX_NP_RX || idx == pnp_pkg::IDX_PORT_CFG;
   endfunction : idx_mapped

   always_comb begin
      nxt_st = st_ff;
      wr_idx = {2'h0, st_ff.awaddr[7:2]};
      rd_idx = {2'h0, s_axi_araddr[7:2]};
      wr_go = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
      rd_go = s_axi_arvalid && st_ff.arready;
      sleep_lim = 32'h0000_0000;

      // Straps land one cycle after reset release, so reset itself loads constants only
      if (!st_ff.strap_done) begin
         nxt_st.strap_done = 1'b1;
         nxt_st.cfg.sleep_enable = sleep_strap;
         nxt_st.cfg.fiber_select = media_select_strap;
      end

      // Address and data are taken independently and held until both are present
      if (s_axi_awvalid && st_ff.awready) begin
         nxt_st.aw_held = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
         nxt_st.awready = 1'b0;
      end
      if (s_axi_wvalid && st_ff.wready) begin
         nxt_st.w_held = 1'b1;
         nxt_st.wdata = s_axi_wdata[15:0];
         nxt_st.wstrb = s_axi_wstrb[1:0];
         nxt_st.wready = 1'b0;
      end
      if (wr_go) begin
         nxt_st.aw_held = 1'b0;
         nxt_st.w_held = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = idx_mapped(wr_idx) ? pnp_pkg::RESP_OKAY : pnp_pkg::RESP_DECERR;
         if (wr_idx == pnp_pkg::IDX_NP_TX) begin
            nxt_st.np_tx = pnp_pkg::pnp_np_word_type'(merge_lanes(st_ff.np_tx, st_ff.wdata, st_ff.wstrb,
                                                                  pnp_pkg::NP_TX_WMASK));
         end else if (wr_idx == pnp_pkg::IDX_PORT_CFG) begin
            nxt_st.cfg = pnp_pkg::pnp_cfg_type'(merge_lanes(st_ff.cfg, st_ff.wdata, st_ff.wstrb,
                                                            pnp_pkg::CFG_WMASK));
         end
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
         nxt_st.awready = 1'b1;
         nxt_st.wready = 1'b1;
      end

      if (rd_go) begin
         nxt_st.arready = 1'b0;
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = idx_mapped(rd_idx) ? pnp_pkg::RESP_OKAY : pnp_pkg::RESP_DECERR;
         nxt_st.rdata = 32'h0000_0000;
         unique case (rd_idx)
            pnp_pkg::IDX_LP_BASE: nxt_st.rdata[15:0] = st_ff.lp_base;
            pnp_pkg::IDX_EXPANSION: begin
               nxt_st.rdata[pnp_pkg::EXP_PAGE_RCVD_BIT] = st_ff.page_rcvd;
               nxt_st.rdata[pnp_pkg::EXP_BASE_PAGE_BIT] = st_ff.base_page;
               // Latched flags clear on read; a page arriving below still sets page_rcvd, and base_page if it is a base page in alt mode
               nxt_st.page_rcvd = 1'b0;
               nxt_st.base_page = 1'b0;
            end
            pnp_pkg::IDX_NP_TX: nxt_st.rdata[15:0] = st_ff.np_tx & pnp_pkg::NP_TX_WMASK;
            pnp_pkg::IDX_NP_RX: nxt_st.rdata[15:0] = st_ff.np_rx;
            pnp_pkg::IDX_PORT_CFG: nxt_st.rdata[15:0] = st_ff.cfg;
            default: nxt_st.rdata = 32'h0000_0000;
         endcase
      end
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
         nxt_st.arready = 1'b1;
      end

      // Hardware toggle wins over a simultaneous software write
      if (np_tx_sent) begin
         nxt_st.np_tx.toggle = ~st_ff.np_tx.toggle;
      end

      if (st_ff.cfg.alt_next_page_enable && (!page_rx_var || st_ff.cfg.tx_disable)) begin
         nxt_st.page_rcvd = 1'b0;
      end
      if (!st_ff.cfg.alt_next_page_enable) begin
         nxt_st.base_page = 1'b0;
      end
      if (page_rx_valid) begin
         if (page_rx_is_next) begin
            nxt_st.np_rx = pnp_pkg::pnp_np_word_type'(page_rx_word);
         end else begin
            nxt_st.lp_base = page_rx_word;
            nxt_st.base_page = st_ff.cfg.alt_next_page_enable;
         end
         nxt_st.page_rcvd = 1'b1;
      end

      unique case (st_ff.cfg.sleep_delay)
         2'h0: sleep_lim = SLEEP_CYC_0;
         2'h1: sleep_lim = SLEEP_CYC_1;
         2'h2: sleep_lim = SLEEP_CYC_2;
         2'h3: sleep_lim = 32'h0000_0000;
      endcase
      // Unused delay code never enters sleep rather than guessing a time
      if (!st_ff.cfg.sleep_enable || !link_idle || st_ff.cfg.sleep_delay == pnp_pkg::SLEEP_CODE_UNUSED) begin
         nxt_st.sleep_cnt = 32'h0000_0000;
         nxt_st.sleep_active = 1'b0;
      end else if (st_ff.sleep_cnt >= sleep_lim - 32'h0000_0001) begin
         nxt_st.sleep_active = 1'b1;
      end else begin
         nxt_st.sleep_cnt = st_ff.sleep_cnt + 32'h0000_0001;
      end

      nxt_st.crs_out = crs_in | (st_ff.cfg.crs_extend & !speed_100 & rx_dv_in);
      // Preamble always passes at 100M
      nxt_st.rx_dv_out = (st_ff.cfg.preamble_enable | speed_100) ? (crs_in | rx_dv_in) : rx_dv_in;

      nxt_st.ctl.force_link_pass = st_ff.cfg.force_link_pass;
      nxt_st.ctl.tx_enable = !st_ff.cfg.tx_disable;
      nxt_st.ctl.scrambler_bypass = st_ff.cfg.scrambler_bypass & speed_100;
      nxt_st.ctl.jabber_disable = st_ff.cfg.jabber_disable & !speed_100;
      nxt_st.ctl.heartbeat_enable = st_ff.cfg.heartbeat_enable & !speed_100;
      nxt_st.ctl.loopback_disable = st_ff.cfg.loopback_disable & !speed_100 & !full_duplex;
      nxt_st.ctl.fefi_enable = st_ff.cfg.fefi_enable;
      nxt_st.ctl.fiber_select = st_ff.cfg.fiber_select;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= pnp_pkg::ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign s_axi_awready = st_ff.awready;
   assign s_axi_wready = st_ff.wready;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rresp = st_ff.rresp;
   assign s_axi_rdata = st_ff.rdata;
   assign np_tx_word = st_ff.np_tx;
   assign phy_ctl = st_ff.ctl;
   assign sleep_active = st_ff.sleep_active;
   assign crs_out = st_ff.crs_out;
   assign rx_dv_out = st_ff.rx_dv_out;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence tx_page_sent_s;
      np_tx_sent && !wr_go;
   endsequence

   sequence next_page_in_s;
      page_rx_valid && page_rx_is_next;
   endsequence

   reset_values_a: assert property ($past(!aresetn) |-> st_ff.np_tx == pnp_pkg::NP_TX_RST
      && st_ff.cfg.crs_extend && st_ff.cfg.fefi_enable && !st_ff.cfg.alt_next_page_enable && st_ff.np_rx == 16'h0000)
      else $error("Register reset values wrong");
   toggle_flip_a: assert property (tx_page_sent_s |=> st_ff.np_tx.toggle != $past(st_ff.np_tx.toggle))
      else $error("Toggle did not flip after page sent");
   np_load_a: assert property (next_page_in_s |=> st_ff.np_rx == $past(page_rx_word) && st_ff.page_rcvd)
      else $error("Next page not loaded");
   page_set_wins_a: assert property (page_rx_valid |=> st_ff.page_rcvd)
      else $error("Page received flag lost");
   alt_clear_a: assert property (st_ff.cfg.alt_next_page_enable && !page_rx_var && !page_rx_valid
      |=> !st_ff.page_rcvd)
      else $error("Page received flag not cleared");
   tx_off_clear_a: assert property (st_ff.cfg.alt_next_page_enable && st_ff.cfg.tx_disable && !page_rx_valid
      |=> !st_ff.page_rcvd)
      else $error("Page received flag kept while transmitter off");
   base_flag_a: assert property (st_ff.base_page |-> $past(st_ff.cfg.alt_next_page_enable))
      else $error("Base page flag without alternate mode");
   crs_extend_a: assert property (st_ff.cfg.crs_extend && !speed_100 && rx_dv_in |=> crs_out)
      else $error("CRS not extended");
   preamble_gate_a: assert property (!st_ff.cfg.preamble_enable && !speed_100 && crs_in && !rx_dv_in
      |=> !rx_dv_out)
      else $error("RX_DV raised before SFD");
   sleep_gate_a: assert property (sleep_active |-> $past(st_ff.cfg.sleep_enable)
      && $past(st_ff.cfg.sleep_delay) != pnp_pkg::SLEEP_CODE_UNUSED && $past(link_idle))
      else $error("Sleep entered while not allowed");
   scram_gate_a: assert property (phy_ctl.scrambler_bypass
      |-> $past(speed_100) && $past(st_ff.cfg.scrambler_bypass))
      else $error("Scrambler bypass outside 100M");
   tx_disable_a: assert property (st_ff.cfg.tx_disable |=> !phy_ctl.tx_enable)
      else $error("Transmitter not disabled");

endmodule : pnp_regs

/* File: bench/pnp_partner.sv */
// Link partner model: delivers received pages and transmit-done pulses
`timescale 1ns/100ps

module pnp_partner (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic send_page,
   input wire logic send_next,
   input wire logic [15:0] send_word,
   input wire logic send_tx_done,
   output logic page_rx_valid,
   output logic page_rx_is_next,
   output logic [15:0] page_rx_word,
   output logic np_tx_sent
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         page_rx_valid <= 1'b0;
         np_tx_sent <= 1'b0;
         page_rx_is_next <= 1'b0;
         page_rx_word <= 16'h0000;
      end else begin
         page_rx_valid <= send_page;
         np_tx_sent <= send_tx_done;
         // Word qualifies only the pulse; scrambled otherwise so stale data cannot pass
         page_rx_is_next <= send_page ? send_next : ~page_rx_is_next;
         page_rx_word <= send_page ? send_word : ~page_rx_word;
      end
   end
endmodule : pnp_partner

/* File: bench/test_phy_next_page_and_port_config_regs.sv */
// Self-checking bench for the next-page and port configuration register bank
`timescale 1ns/100ps

module test_phy_next_page_and_port_config_regs;
   localparam int S0 = 20;
   localparam int S1 = 12;
   localparam int S2 = 6;
   localparam logic [1:0] OK = pnp_pkg::RESP_OKAY;
   localparam logic [1:0] DEC = pnp_pkg::RESP_DECERR;
   localparam logic [7:0] A_EXP = pnp_pkg::IDX_EXPANSION << 2;
   localparam logic [7:0] A_TX = pnp_pkg::IDX_NP_TX << 2;
   localparam logic [7:0] A_RX = pnp_pkg::IDX_NP_RX << 2;
   localparam logic [7:0] A_CFG = pnp_pkg::IDX_PORT_CFG << 2;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic strap_s, strap_m, send_page, send_next, send_tx_done, page_rx_var;
   logic speed_100, full_duplex, link_idle, crs_in, rx_dv_in;
   logic page_rx_valid, page_rx_is_next, np_tx_sent, sleep_active, crs_out, rx_dv_out;
   logic [15:0] send_word, page_rx_word, pw, c;
   pnp_pkg::pnp_np_word_type np_tx_word;
   pnp_pkg::pnp_phy_ctl_type phy_ctl;
   logic [33:0] exp_q[$];
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int lims[4] = '{S0, S1, S2, S0};

   pnp_regs #(.SLEEP_CYC_0(S0), .SLEEP_CYC_1(S1), .SLEEP_CYC_2(S2)) u_pnp_regs (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(rready),
      .sleep_strap(strap_s), .media_select_strap(strap_m), .page_rx_valid(page_rx_valid),
      .page_rx_is_next(page_rx_is_next), .page_rx_word(page_rx_word), .page_rx_var(page_rx_var),
      .np_tx_sent(np_tx_sent), .speed_100(speed_100), .full_duplex(full_duplex), .link_idle(link_idle),
      .crs_in(crs_in), .rx_dv_in(rx_dv_in), .np_tx_word(np_tx_word), .phy_ctl(phy_ctl),
      .sleep_active(sleep_active), .crs_out(crs_out), .rx_dv_out(rx_dv_out));

   pnp_partner u_pnp_partner (
      .aclk(aclk), .aresetn(aresetn), .send_page(send_page), .send_next(send_next), .send_word(send_word),
      .send_tx_done(send_tx_done), .page_rx_valid(page_rx_valid), .page_rx_is_next(page_rx_is_next),
      .page_rx_word(page_rx_word), .np_tx_sent(np_tx_sent));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic finish_test;
      $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   function automatic logic [33:0] ok(input logic [15:0] v);
      return {OK, 16'h0000, v};
   endfunction : ok

   task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] rsp);
      exp_q.push_back({rsp, 32'h0000_0000});
      awaddr <= a;
      wdata <= {16'h0000, d};
      wstrb <= 4'hF;
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) wvalid <= 1'b0;
      end while ((awvalid && s_axi_awready !== 1'b1) || (wvalid && s_axi_wready !== 1'b1));
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      bready <= 1'b0;
      @(posedge aclk);
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
      exp_q.push_back(e);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_rd

   task automatic page(input logic nxt, input logic [15:0] w);
      {send_page, send_next, send_word} <= {1'b1, nxt, w};
      @(posedge aclk);
      send_page <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask : page

   // Response monitor: oldest note is matched against each completed answer
   always @(posedge aclk) begin
      if (s_axi_bvalid === 1'b1 && bready) check({s_axi_bresp, 32'h0000_0000}, exp_q.pop_front());
      if (s_axi_rvalid === 1'b1 && rready) check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
   end

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_errors++;
         finish_test();
      end
   end

   initial begin
      void'($urandom(26870));
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
      {send_page, send_next, send_tx_done, page_rx_var, send_word} = '0;
      {speed_100, full_duplex, link_idle, crs_in, rx_dv_in} = '0;
      strap_s = 1'($urandom);
      strap_m = 1'($urandom);
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      axi_rd(A_TX, ok(16'h2001));
      axi_rd(A_RX, ok(16'h0000));
      axi_rd(A_CFG, ok(16'h0084 | {9'h000, strap_s, 5'h00, strap_m}));
      $display("reset values done");
      pw = 16'($urandom);
      axi_wr(A_TX, pw | 16'h4000, OK);
      axi_rd(A_TX, ok(pw & 16'hBFFF));
      check({18'h00000, np_tx_word}, {18'h00000, pw & 16'hBFFF});
      send_tx_done <= 1'b1;
      @(posedge aclk);
      send_tx_done <= 1'b0;
      repeat (3) @(posedge aclk);
      axi_rd(A_TX, ok((pw & 16'hBFFF) ^ 16'h0800));
      $display("transmit page done");
      axi_wr(A_RX, 16'hFFFF, OK);
      axi_rd(A_RX, ok(16'h0000));
      axi_wr(8'h3C, 16'h1234, DEC);
      axi_rd(8'h3C, {DEC, 32'h0000_0000});
      $display("read-only and unmapped done");
      page(1'b1, pw);
      axi_rd(A_RX, ok(pw));
      axi_rd(A_EXP, ok(16'h0002));
      axi_rd(A_EXP, ok(16'h0000));
      page_rx_var <= 1'b1;
      axi_wr(A_CFG, 16'h0086, OK);
      page(1'b0, ~pw);
      axi_rd(A_EXP, ok(16'h0022));
      axi_rd(A_RX, ok(pw));
      page(1'b1, pw);
      page_rx_var <= 1'b0;
      repeat (3) @(posedge aclk);
      axi_rd(A_EXP, ok(16'h0000));
      // Variable held true so only the transmitter-off path can clear the flag
      page_rx_var <= 1'b1;
      axi_wr(A_CFG, 16'h2002, OK);
      page(1'b1, pw);
      axi_rd(A_EXP, ok(16'h0000));
      $display("received pages done");
      for (int i = 0; i < 8; i++) begin
         // Reserved bits and sleep kept clear
         c = 16'($urandom) & 16'h77A7;
         {speed_100, full_duplex, crs_in, rx_dv_in} <= 4'($urandom);
         axi_wr(A_CFG, c, OK);
         axi_rd(A_CFG, ok(c));
         check({26'h0, phy_ctl}, {26'h0, c[14], ~c[13], c[12] & speed_100, c[10] & ~speed_100, c[9] & ~speed_100,
            c[8] & ~speed_100 & ~full_duplex, c[2], c[0]});
         check({32'h0, crs_out, rx_dv_out}, {32'h0, crs_in | (c[7] & ~speed_100 & rx_dv_in),
            (c[5] | speed_100) ? (crs_in | rx_dv_in) : rx_dv_in});
      end
      $display("configuration outputs done");
      for (int k = 0; k < 4; k++) begin
         link_idle <= 1'b0;
         axi_wr(A_CFG, 16'h0040 | 16'(k << 3), OK);
         link_idle <= 1'b1;
         repeat (lims[k] - 2) @(posedge aclk);
         check({33'h0, sleep_active}, 34'h0);
         repeat (6) @(posedge aclk);
         check({33'h0, sleep_active}, {33'h0, k != 3});
      end
      link_idle <= 1'b0;
      $display("sleep delay done");
      finish_test();
   end
endmodule : test_phy_next_page_and_port_config_regs
